// ==== hdl/dinp_input_port.sv ====
// Purpose: Six-pin input port with clear-to-send and external clock roles.
// Assumes: Pins are asynchronous inputs; strobes are one cycle long.
// Notes:   Pin state reads two cycles behind the pin, after resync.
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/10ps
`include "dinp_defs.svh"

module dinp_input_port (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        reset_n_i,
  // Pins
  input  wire logic [`DINP_PIN_W-1:0]      input_pin_n_i,
  // Rate sources
  input  wire logic [`DINP_BRG_RATES-1:0]  baud_rate_generator_tick_i,
  input  wire logic                        timer_out_tick_i,
  // Register port
  input  wire logic [`DINP_ADDR_W-1:0]     addr_i,
  input  wire logic [`DINP_DATA_W-1:0]     wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output logic      [`DINP_DATA_W-1:0]     rdata_o,
  // Flow control
  output logic                             chan_a_clear_to_send_n_o,
  output logic                             chan_b_clear_to_send_n_o,
  // Counter/timer clock
  output logic                             timer_ext_clock_in_sel_o,
  output logic                             timer_ext_clock_in_tick_o,
  // Channel bit ticks
  output logic      [`DINP_CHANS-1:0]      bit_tick_o
);

  // ==========================================================
  // Source decoding
  function automatic dinp_pkg::dinp_src_e src_kind(input logic [3:0] code,
                                                    input logic       set2);
    dinp_pkg::dinp_src_e k;
    k = dinp_pkg::DINP_SRC_NONE;
    if (code == `DINP_CS_EXT1) begin
      k = dinp_pkg::DINP_SRC_EXT1;
    end else if (code == `DINP_CS_EXT16) begin
      k = dinp_pkg::DINP_SRC_EXT16;
    end else if (code == `DINP_CS_TIMER) begin
      k = dinp_pkg::DINP_SRC_TIMER;
    end else if ((!set2 && code <= `DINP_SET1_LAST) ||
                 (set2 && code <= `DINP_SET2_LAST)) begin
      k = dinp_pkg::DINP_SRC_BRG;
    end
    return k;
  endfunction

  // Result is {tick, is_1x}; rate codes of both sets share one tick bus
  function automatic logic [1:0] pick_src(input logic [3:0]                code,
                                          input logic                      set2,
                                          input logic                      ext_edge,
                                          input logic [`DINP_BRG_RATES-1:0] baud_rate_generator,
                                          input logic                      tmr);
    logic [4:0] idx;
    logic [1:0] r;
    idx = set2 ? ({1'b0, code} + `DINP_SET2_BASE) : {1'b0, code};
    r   = 2'b00;
    case (src_kind(code, set2))
      dinp_pkg::DINP_SRC_BRG: begin
        r = {baud_rate_generator[idx], 1'b0};
      end
      dinp_pkg::DINP_SRC_TIMER: begin
        r = {tmr, 1'b0};
      end
      dinp_pkg::DINP_SRC_EXT16: begin
        r = {ext_edge, 1'b0};
      end
      dinp_pkg::DINP_SRC_EXT1: begin
        r = {ext_edge, 1'b1};
      end
      default: begin
        r = 2'b00;
      end
    endcase
    return r;
  endfunction

  function automatic logic is_ext(input logic [3:0] code, input logic set2);
    dinp_pkg::dinp_src_e k;
    k = src_kind(code, set2);
    return (k == dinp_pkg::DINP_SRC_EXT16) || (k == dinp_pkg::DINP_SRC_EXT1);
  endfunction

  // ==========================================================
  // State
  dinp_pkg::dinp_port_s     q;
  dinp_pkg::dinp_port_s     d;
  logic [`DINP_PIN_W-1:0]   rise;
  logic [1:0]               sel_a_tx;
  logic [1:0]               sel_a_rx;
  logic [1:0]               sel_b_tx;
  logic [1:0]               sel_b_rx;
  logic [`DINP_CHANS-1:0]   ext_use;
  logic                     set2;

  always_comb begin
    d        = q;
    // Only the second stage ever looks at the first
    d.sync1  = input_pin_n_i;
    d.sync2  = q.sync1;
    d.sync3  = q.sync2;
    rise     = q.sync2 & ~q.sync3;
    set2     = q.aux[`DINP_AUX_SET_BIT];

    sel_a_tx = pick_src(q.csa[3:0], set2, rise[`DINP_PIN_A_TX],
                        baud_rate_generator_tick_i, timer_out_tick_i);
    sel_a_rx = pick_src(q.csa[7:4], set2, rise[`DINP_PIN_A_RX],
                        baud_rate_generator_tick_i, timer_out_tick_i);
    sel_b_tx = pick_src(q.csb[3:0], set2, rise[`DINP_PIN_B_TX],
                        baud_rate_generator_tick_i, timer_out_tick_i);
    sel_b_rx = pick_src(q.csb[7:4], set2, rise[`DINP_PIN_B_RX],
                        baud_rate_generator_tick_i, timer_out_tick_i);
    ext_use  = {is_ext(q.csb[7:4], set2), is_ext(q.csb[3:0], set2),
                is_ext(q.csa[7:4], set2), is_ext(q.csa[3:0], set2)};

    d.src_tick = {sel_b_rx[1], sel_b_tx[1], sel_a_rx[1], sel_a_tx[1]};
    d.src_1x   = {sel_b_rx[0], sel_b_tx[0], sel_a_rx[0], sel_a_tx[0]};
    d.src_clr  = 4'h0;

    // Unselected clear-to-send reads as clear so the channel never stalls
    d.cts_a_n  = q.chan_a_mode_reg2[`DINP_MR2_CTS_BIT] ? q.sync2[`DINP_PIN_CTS_A] : 1'b0;
    d.cts_b_n  = q.chan_b_mode_reg2[`DINP_MR2_CTS_BIT] ? q.sync2[`DINP_PIN_CTS_B] : 1'b0;
    d.tmr_sel  = (q.aux[`DINP_AUX_TMR_MSB:`DINP_AUX_TMR_LSB] == `DINP_TMR_EXT_CODE);
    d.tmr_tick = d.tmr_sel && rise[`DINP_PIN_B_RX];

    if (wr_i) begin
      case (addr_i)
        `DINP_OFF_CHAN_A_MODE_REG2: begin
          d.chan_a_mode_reg2 = wdata_i;
        end
        `DINP_OFF_CHAN_B_MODE_REG2: begin
          d.chan_b_mode_reg2 = wdata_i;
        end
        `DINP_OFF_AUX: begin
          d.aux     = wdata_i;
          d.src_clr = 4'hF;
        end
        `DINP_OFF_CSA: begin
          d.csa     = wdata_i;
          d.src_clr = 4'h3;
        end
        `DINP_OFF_CSB: begin
          d.csb     = wdata_i;
          d.src_clr = 4'hC;
        end
        default: begin
          d.src_clr = 4'h0;
        end
      endcase
    end

    d.rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        `DINP_OFF_PIN_STATE: begin
          // Live level whatever role the pin has
          d.rdata = {2'h0, q.sync2};
        end
        `DINP_OFF_CHAN_A_MODE_REG2: begin
          d.rdata = q.chan_a_mode_reg2;
        end
        `DINP_OFF_CHAN_B_MODE_REG2: begin
          d.rdata = q.chan_b_mode_reg2;
        end
        `DINP_OFF_AUX: begin
          d.rdata = q.aux;
        end
        `DINP_OFF_CSA: begin
          d.rdata = q.csa;
        end
        `DINP_OFF_CSB: begin
          d.rdata = q.csb;
        end
        `DINP_OFF_EXT_USE: begin
          d.rdata = {4'h0, ext_use};
        end
        default: begin
          d.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q       <= '0;
      q.chan_a_mode_reg2  <= `DINP_RST_REG;
      q.chan_b_mode_reg2  <= `DINP_RST_REG;
      q.aux   <= `DINP_RST_REG;
      q.csa   <= `DINP_RST_REG;
      q.csb   <= `DINP_RST_REG;
      q.sync1 <= `DINP_RST_PINS;
      q.sync2 <= `DINP_RST_PINS;
      q.sync3 <= `DINP_RST_PINS;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Bit-rate dividers
  for (genvar g = 0; g < `DINP_CHANS; g++) begin : g_div
    dinp_rate_div u_div (
      .clk_i      (clk_i),
      .reset_n_i  (reset_n_i),
      .tick_i     (q.src_tick[g]),
      .mode_1x_i  (q.src_1x[g]),
      .clr_i      (q.src_clr[g]),
      .bit_tick_o (bit_tick_o[g])
    );
  end

  // ==========================================================
  // Outputs
  assign rdata_o                   = q.rdata;
  assign chan_a_clear_to_send_n_o  = q.cts_a_n;
  assign chan_b_clear_to_send_n_o  = q.cts_b_n;
  assign timer_ext_clock_in_sel_o  = q.tmr_sel;
  assign timer_ext_clock_in_tick_o = q.tmr_tick;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_pin_sync_delay: assert property (
    ##2 (q.sync2 == $past(input_pin_n_i, 2)))
    else $error("Pin resync is not two stages");

  a_pin_state_read: assert property (
    (rd_i && addr_i == `DINP_OFF_PIN_STATE) |=> rdata_o == {2'h0, $past(q.sync2)})
    else $error("Pin state read mismatch");

  a_pin_read_any: assert property (
    (rd_i && addr_i == `DINP_OFF_PIN_STATE) ##1 1'b1 |-> ##2
    ($past(rdata_o, 2) == {2'h0, $past(input_pin_n_i, 5)}))
    else $error("Pin read not tied to pin");

  a_alt_true_level: assert property (
    (rd_i && addr_i == `DINP_OFF_PIN_STATE && q.csa == 8'hFF && q.chan_a_mode_reg2[4])
    |=> rdata_o[4:0] == $past(q.sync2[4:0]))
    else $error("Alternate role hid pin level");

  a_cts_a_follow: assert property (
    1'b1 |=> chan_a_clear_to_send_n_o == ($past(q.chan_a_mode_reg2[4]) & $past(q.sync2[0])))
    else $error("Channel A clear-to-send wrong");

  a_cts_b_follow: assert property (
    1'b1 |=> chan_b_clear_to_send_n_o == ($past(q.chan_b_mode_reg2[4]) & $past(q.sync2[1])))
    else $error("Channel B clear-to-send wrong");

  a_timer_ext_edge: assert property (
    (q.aux[6:4] == 3'h0 && q.sync2[2] && !q.sync3[2]) |=> timer_ext_clock_in_tick_o)
    else $error("Timer missed pin edge");

  a_timer_ext_off: assert property (
    (q.aux[6:4] != 3'h0) |=> !timer_ext_clock_in_tick_o && !timer_ext_clock_in_sel_o)
    else $error("Timer took pin while not selected");

  a_b_rx_ext16: assert property (
    (q.csb[7:4] == 4'hE && q.sync2[2] && !q.sync3[2]) |=> q.src_tick[3] && !q.src_1x[3])
    else $error("Channel B receiver ext clock lost");

  a_a_tx_ext1: assert property (
    (q.csa[3:0] == 4'hF && q.sync2[3] && !q.sync3[3]) |=> q.src_tick[0] && q.src_1x[0])
    else $error("Channel A transmitter ext clock lost");

  a_a_rx_ext16: assert property (
    (q.csa[7:4] == 4'hE && q.sync2[4] && !q.sync3[4]) |=> q.src_tick[1] && !q.src_1x[1])
    else $error("Channel A receiver ext clock lost");

  a_b_tx_ext1: assert property (
    (q.csb[3:0] == 4'hF && q.sync2[5] && !q.sync3[5]) |=> q.src_tick[2] && q.src_1x[2])
    else $error("Channel B transmitter ext clock lost");

  a_ext1_no_div: assert property (
    (q.src_tick[0] && q.src_1x[0] && !q.src_clr[0]) |=> bit_tick_o[0])
    else $error("1X clock was divided");

  a_brg_rate_pick: assert property (
    (q.csa[3:0] == 4'h0 && !q.aux[7] && baud_rate_generator_tick_i[0]) |=> q.src_tick[0])
    else $error("Baud generator rate not routed");

  a_timer_as_rate: assert property (
    (q.csb[3:0] == 4'hD && timer_out_tick_i) |=> q.src_tick[2] && !q.src_1x[2])
    else $error("Timer rate not routed");

endmodule

// ==== include/dinp_defs.svh ====
// Purpose: Constants of the input port with alternate pin functions.
// Assumes: Included by the package and by the design modules.
// Notes:   Offsets address the plain register port, one byte each.
`ifndef DINP_DEFS_SVH
`define DINP_DEFS_SVH

// ==========================================================
// Sizes
`define DINP_PIN_W         6
`define DINP_ADDR_W        4
`define DINP_DATA_W        8
`define DINP_BRG_RATES     23
`define DINP_CHANS         4

// ==========================================================
// Register offsets
`define DINP_OFF_PIN_STATE 4'h0
`define DINP_OFF_CHAN_A_MODE_REG2      4'h1
`define DINP_OFF_CHAN_B_MODE_REG2      4'h2
`define DINP_OFF_AUX       4'h3
`define DINP_OFF_CSA       4'h4
`define DINP_OFF_CSB       4'h5
`define DINP_OFF_EXT_USE   4'h6

// ==========================================================
// Reset values
`define DINP_RST_REG       8'h00
`define DINP_RST_PINS      6'h00

// ==========================================================
// Field positions and codes
`define DINP_MR2_CTS_BIT   4
`define DINP_AUX_SET_BIT   7
`define DINP_AUX_TMR_MSB   6
`define DINP_AUX_TMR_LSB   4
`define DINP_TMR_EXT_CODE  3'h0
`define DINP_CS_TIMER      4'hD
`define DINP_CS_EXT16      4'hE
`define DINP_CS_EXT1       4'hF
`define DINP_SET1_LAST     4'hC
`define DINP_SET2_LAST     4'h9
`define DINP_SET2_BASE     5'h0D
`define DINP_DIV16_LAST    4'hF

// ==========================================================
// Pin roles
`define DINP_PIN_CTS_A     0
`define DINP_PIN_CTS_B     1
`define DINP_PIN_B_RX      2
`define DINP_PIN_A_TX      3
`define DINP_PIN_A_RX      4
`define DINP_PIN_B_TX      5

// ==========================================================
// Bit-tick channel order
`define DINP_CH_A_TX       0
`define DINP_CH_A_RX       1
`define DINP_CH_B_TX       2
`define DINP_CH_B_RX       3

`endif

// ==== include/dinp_pkg.sv ====
// Purpose: Types of the input port with alternate pin functions.
// Assumes: dinp_defs.svh supplies the port state widths; enum codes and divider width are literal.
// Notes:   State of each design module is one packed struct.
`include "dinp_defs.svh"

package dinp_pkg;

  // ==========================================================
  // Clock source kinds
  typedef enum logic [2:0] {
    DINP_SRC_NONE  = 3'b000,
    DINP_SRC_BRG   = 3'b001,
    DINP_SRC_TIMER = 3'b010,
    DINP_SRC_EXT16 = 3'b011,
    DINP_SRC_EXT1  = 3'b100
  } dinp_src_e;

  // ==========================================================
  // Port state
  typedef struct packed {
    logic [`DINP_PIN_W-1:0]  sync1;
    logic [`DINP_PIN_W-1:0]  sync2;
    logic [`DINP_PIN_W-1:0]  sync3;
    logic [`DINP_DATA_W-1:0] chan_a_mode_reg2;
    logic [`DINP_DATA_W-1:0] chan_b_mode_reg2;
    logic [`DINP_DATA_W-1:0] aux;
    logic [`DINP_DATA_W-1:0] csa;
    logic [`DINP_DATA_W-1:0] csb;
    logic [`DINP_DATA_W-1:0] rdata;
    logic                    cts_a_n;
    logic                    cts_b_n;
    logic                    tmr_sel;
    logic                    tmr_tick;
    logic [`DINP_CHANS-1:0]  src_tick;
    logic [`DINP_CHANS-1:0]  src_1x;
    logic [`DINP_CHANS-1:0]  src_clr;
  } dinp_port_s;

  // ==========================================================
  // Divider state
  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
  } dinp_div_s;

endpackage

// ==== hdl/dinp_rate_div.sv ====
// Purpose: Turns a source tick stream into bit ticks, by 16 or by 1.
// Assumes: tick_i is a one-cycle pulse per source clock period.
// Notes:   clr_i restarts the phase when the source is reselected.
`timescale 1ns/10ps
`include "dinp_defs.svh"

module dinp_rate_div (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // Source
  input  wire logic tick_i,
  input  wire logic mode_1x_i,
  input  wire logic clr_i,
  // Bit tick
  output logic      bit_tick_o
);

  dinp_pkg::dinp_div_s q;
  dinp_pkg::dinp_div_s d;

  always_comb begin
    d      = q;
    d.tick = 1'b0;
    if (clr_i) begin
      d.cnt = 4'h0;
    end else if (mode_1x_i) begin
      d.cnt  = 4'h0;
      d.tick = tick_i;
    end else if (tick_i) begin
      d.cnt  = q.cnt + 4'h1;
      d.tick = (q.cnt == `DINP_DIV16_LAST);
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bit_tick_o = q.tick;

  // ==========================================================
  // Checks
  a_div16_wrap: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (tick_i && !mode_1x_i && !clr_i && q.cnt == 4'hF) |=> bit_tick_o)
    else $error("16X divider missed its wrap");

  a_div16_quiet: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (!mode_1x_i && q.cnt != 4'hF) |=> !bit_tick_o)
    else $error("16X divider ticked early");

endmodule

// ==== test/dinp_pin_model.sv ====
// Purpose: Far side of the input port: pin levels and clock bursts.
// Assumes: Bench changes the controls right after a rising edge.
// Notes:   Clocked pins idle low between bursts, like a gated source.
`timescale 1ns/10ps

module dinp_pin_model (
  // Clock
  input  wire logic       clk_i,
  // Control
  input  wire logic       go_i,
  input  wire logic [5:0] mask_i,
  input  wire logic [5:0] level_i,
  input  wire logic [3:0] half_i,
  input  wire logic [7:0] pulses_i,
  // Pins
  output logic      [5:0] pins_o
);
  logic [7:0] left_q;
  logic [3:0] cnt_q;
  logic       ph_q;

  // ==========================================================
  // Burst of pulses_i clock periods, high and low half_i cycles each
  always_ff @(posedge clk_i) begin
    if (!go_i) begin
      left_q <= pulses_i;
      cnt_q  <= 4'h0;
      ph_q   <= 1'b0;
    end else if (left_q != 8'h00) begin
      if (cnt_q == half_i - 4'h1) begin
        cnt_q <= 4'h0;
        ph_q  <= ~ph_q;
        if (ph_q) begin
          left_q <= left_q - 8'h01;
        end
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  // Data for a 1X clock would have to follow this same phase
  assign pins_o = (ph_q ? mask_i : 6'h00) | (level_i & ~mask_i);
endmodule

// ==== test/dinp_input_port_bench.sv ====
// Purpose: Self-checking bench of the input port with pin roles.
// Assumes: Pin model drives the pins; bench drives ticks and registers.
// Notes:   Seeded random pin levels and mode values, fixed corner cases.
`timescale 1ns/10ps
`include "dinp_defs.svh"

module dinp_input_port_bench;
  logic                       clk_i;
  logic                       reset_n_i;
  logic [`DINP_PIN_W-1:0]     pins;
  logic [`DINP_BRG_RATES-1:0] brg_tick;
  logic                       tmr_tick;
  logic [`DINP_ADDR_W-1:0]    addr_i;
  logic [`DINP_DATA_W-1:0]    wdata_i;
  logic [`DINP_DATA_W-1:0]    rdata_o;
  logic                       wr_i;
  logic                       rd_i;
  logic                       cts_a_n;
  logic                       cts_b_n;
  logic                       tmr_sel;
  logic                       tmr_ext;
  logic [`DINP_CHANS-1:0]     bit_tick;
  logic                       go;
  logic [5:0]                 mask;
  logic [5:0]                 level;
  logic [7:0]                 rv;
  int                         error_cnt;
  int                         n_compared;
  int                         cyc;
  int                         tmr_cnt;
  int                         tick_cnt [`DINP_CHANS];

  dinp_input_port dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .input_pin_n_i(pins),
    .baud_rate_generator_tick_i(brg_tick), .timer_out_tick_i(tmr_tick),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .chan_a_clear_to_send_n_o(cts_a_n), .chan_b_clear_to_send_n_o(cts_b_n),
    .timer_ext_clock_in_sel_o(tmr_sel), .timer_ext_clock_in_tick_o(tmr_ext),
    .bit_tick_o(bit_tick));

  dinp_pin_model partner (
    .clk_i(clk_i), .go_i(go), .mask_i(mask), .level_i(level),
    .half_i(4'h4), .pulses_i(8'h20), .pins_o(pins));

  // ==========================================================
  // Clock, tick counters and hang guard
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc++;
    if (tmr_ext === 1'b1) tmr_cnt++;
    for (int i = 0; i < `DINP_CHANS; i++) if (bit_tick[i] === 1'b1) tick_cnt[i]++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  // ==========================================================
  // Helpers
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic reg_wr(logic [3:0] a, logic [7:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Read data only in the cycle after the strobe, zero after it
  task automatic expect_rd(logic [3:0] a, logic [7:0] exp);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 check("read data", exp, rdata_o);
    @(posedge clk_i);
    #1 check("idle read data", 8'h00, rdata_o);
    @(posedge clk_i);
  endtask

  task automatic clr_cnt();
    tmr_cnt  = 0;
    tick_cnt = '{default: 0};
  endtask

  function automatic logic [7:0] exp_ticks(logic [3:0] nib, int edges);
    if (nib == `DINP_CS_EXT1) return 8'(edges);
    if (nib == `DINP_CS_EXT16) return 8'(edges / 16);
    return 8'h00;
  endfunction

  // 32 pin clock periods on the masked pins, then count what came out
  task automatic ext_round(logic [7:0] ca, logic [7:0] cb, logic [7:0] ax, logic [5:0] m);
    logic [3:0] nib [4];
    int         pin [4];
    pin = '{`DINP_PIN_A_TX, `DINP_PIN_A_RX, `DINP_PIN_B_TX, `DINP_PIN_B_RX};
    nib = '{ca[3:0], ca[7:4], cb[3:0], cb[7:4]};
    reg_wr(`DINP_OFF_CSA, ca);
    reg_wr(`DINP_OFF_CSB, cb);
    reg_wr(`DINP_OFF_AUX, ax);
    mask <= m;
    clr_cnt();
    go <= 1'b1;
    repeat (270) @(posedge clk_i);
    go <= 1'b0;
    // Look after the edge so counters and outputs have settled
    #1;
    for (int i = 0; i < 4; i++)
      check("ticks", exp_ticks(nib[i], m[pin[i]] ? 32 : 0), 8'(tick_cnt[i]));
    check("timer ticks", (ax[6:4] == 3'h0 && m[2]) ? 8'h20 : 8'h00, 8'(tmr_cnt));
    check("timer select", {7'h00, ax[6:4] == 3'h0}, {7'h00, tmr_sel});
    $display("ext clock round %h %h %h %h done", ca, cb, ax, m);
    @(posedge clk_i);
  endtask

  task automatic pulse16(logic [22:0] b, logic t);
    repeat (16) begin
      brg_tick <= b;
      tmr_tick <= t;
      @(posedge clk_i);
      brg_tick <= 23'h0;
      tmr_tick <= 1'b0;
      @(posedge clk_i);
    end
    repeat (6) @(posedge clk_i);
  endtask

  // Only the selected source, divided by sixteen, reaches A tx
  task automatic src_round(logic [7:0] ax, logic [3:0] code, logic [22:0] hit, logic thit);
    reg_wr(`DINP_OFF_AUX, ax);
    reg_wr(`DINP_OFF_CSA, {4'h0, code});
    clr_cnt();
    pulse16(~hit, ~thit);
    check("other source ticks", 8'h00, 8'(tick_cnt[`DINP_CH_A_TX]));
    clr_cnt();
    pulse16(hit, thit);
    check("source ticks", 8'h01, 8'(tick_cnt[`DINP_CH_A_TX]));
  endtask

  // ==========================================================
  // Tests
  initial begin
    {reset_n_i, brg_tick, tmr_tick, addr_i, wdata_i, wr_i, rd_i} = '0;
    {go, mask, level, error_cnt, n_compared, cyc} = '0;
    clr_cnt();
    void'($urandom(89));
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    for (int a = 0; a < 7; a++) expect_rd(4'(a), 8'h00);
    expect_rd(4'hA, 8'h00);
    #1 check("timer select", 8'h01, {7'h00, tmr_sel});
    @(posedge clk_i);
    $display("reset test done");

    for (int n = 0; n < 10; n++) begin
      level <= (n < 2) ? {6{n[0]}} : 6'($urandom);
      repeat (4) @(posedge clk_i);
      expect_rd(`DINP_OFF_PIN_STATE, {2'b00, level});
    end
    $display("pin state test done");

    rv = 8'($urandom) | 8'h10;
    reg_wr(`DINP_OFF_CHAN_A_MODE_REG2, rv);
    expect_rd(`DINP_OFF_CHAN_A_MODE_REG2, rv);
    reg_wr(`DINP_OFF_CHAN_B_MODE_REG2, rv ^ 8'hEF);
    expect_rd(`DINP_OFF_CHAN_B_MODE_REG2, rv ^ 8'hEF);
    // Every pin holds a second role while its level is read
    reg_wr(`DINP_OFF_CSA, 8'hFF);
    reg_wr(`DINP_OFF_CSB, 8'hFF);
    for (int n = 0; n < 8; n++) begin
      level <= 6'($urandom);
      repeat (4) @(posedge clk_i);
      #1;
      check("cts a", {7'h00, level[0]}, {7'h00, cts_a_n});
      check("cts b", {7'h00, level[1]}, {7'h00, cts_b_n});
      @(posedge clk_i);
      expect_rd(`DINP_OFF_PIN_STATE, {2'b00, level});
    end
    reg_wr(`DINP_OFF_CHAN_A_MODE_REG2, 8'h00);
    reg_wr(`DINP_OFF_CHAN_B_MODE_REG2, 8'h00);
    level <= 6'h3F;
    repeat (4) @(posedge clk_i);
    #1;
    check("cts off", 8'h00, {6'h00, cts_b_n, cts_a_n});
    @(posedge clk_i);
    level <= 6'h00;
    $display("clear to send test done");

    reg_wr(`DINP_OFF_CSA, 8'hFF);
    reg_wr(`DINP_OFF_CSB, 8'hFF);
    expect_rd(`DINP_OFF_EXT_USE, 8'h0F);
    for (int p = 2; p < 6; p++) begin
      ext_round(8'hFF, 8'hFF, 8'h00, 6'(1 << p));
    end
    ext_round(8'hFE, 8'hEF, 8'h10, 6'h3C);
    ext_round(8'hEF, 8'hFE, 8'h80, 6'h3C);
    expect_rd(`DINP_OFF_CSA, 8'hEF);

    for (int c = 0; c < 13; c++) src_round(8'h00, 4'(c), 23'h1 << c, 1'b0);
    for (int c = 0; c < 10; c++) src_round(8'h80, 4'(c), 23'h1 << (13 + c), 1'b0);
    // Second set has no rate behind codes A to C
    reg_wr(`DINP_OFF_CSA, 8'h0A);
    clr_cnt();
    pulse16(23'h7FFFFF, 1'b1);
    check("unused code ticks", 8'h00, 8'(tick_cnt[`DINP_CH_A_TX]));
    reg_wr(`DINP_OFF_CSB, 8'hDD);
    src_round(8'h00, `DINP_CS_TIMER, 23'h0, 1'b1);
    $display("rate source test done");
    complete_run();
  end
endmodule
